// >>> ccc_map.svh
// Timing figures, counter widths and reset values of the constant-current chopper
// Notes on behaviour
// - Phases loop Charge, Fast Decay, Slow Decay, then Charge again, continuously.
// - One chopping period is 16 oscillator ticks; phase changes happen inside it.
// - Charge drives the winding until the peak comparator trips, then Fast Decay.
// - Fast Decay ends on the decay-switch comparator; Slow Decay holds to period end.
// - Every gate change passes a 400 ns interval with all transistors off, except the first pattern after a standby clears a fault.
// - The peak comparator is ignored for 1.25 us after Charge begins.
// - The decay comparator is ignored for 2.2 us after entering decay.
// - Charge not finished at period end carries on into the next period.
// - Fast Decay not finished at period end carries on into the next period.
// - Overcurrent turns all transistors off until power cycle or standby entry.
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

// System clock
`define CCC_CLK_NS          10
// Chopping oscillator, fixed internal rate
`define CCC_OSC_KHZ         920
`define CCC_OSC_DIV_CYC     (1000000 / (`CCC_OSC_KHZ * `CCC_CLK_NS))
// Ticks per chopping period
`define CCC_TICKS_PER_CHOP  16
// Dead interval between gate patterns
`define CCC_DEAD_NS         400
`define CCC_DEAD_CYC        ((`CCC_DEAD_NS + `CCC_CLK_NS - 1) / `CCC_CLK_NS)
// Digital blanking windows
`define CCC_PEAK_BLANK_NS   1250
`define CCC_PEAK_BLANK_CYC  ((`CCC_PEAK_BLANK_NS + `CCC_CLK_NS - 1) / `CCC_CLK_NS)
`define CCC_DECAY_BLANK_NS  2200
`define CCC_DECAY_BLANK_CYC ((`CCC_DECAY_BLANK_NS + `CCC_CLK_NS - 1) / `CCC_CLK_NS)
// Counter widths
`define CCC_DIV_W           8
`define CCC_TICK_W          4
`define CCC_DEAD_W          6
`define CCC_BLANK_W         8
// Reset values
`define CCC_GATE_RST        4'h0
`define CCC_FAULT_RST       1'b0

`endif

// >>> ccc_pkg.sv
// Types shared by the constant-current chopper
`default_nettype none
package ccc_pkg;

   typedef enum logic [1:0] {
      CCC_CHARGE,
      CCC_FAST,
      CCC_SLOW,
      CCC_IDLE
   } ccc_phase_t;

   // Gate drives of one H-bridge channel
   typedef struct packed {
      logic hs_pos;
      logic ls_pos;
      logic hs_neg;
      logic ls_neg;
   } ccc_gate_t;

endpackage : ccc_pkg
`default_nettype wire

// >>> ccc_chopper.sv
// Constant-current chopping sequencer for one motor bridge channel
`include "ccc_map.svh"
`default_nettype none

// Three-stage synchroniser; output follows once stages two and three agree
module ccc_sync (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Asynchronous level in, clean level out
   input  wire logic async_i,
   output var  logic level_o
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_o <= 1'b0;
      end else if (s2 == s3) begin
         level_o <= s3;
      end
   end
endmodule : ccc_sync

module ccc_chopper (
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_n_i,
   // Analog comparators and protection
   input  wire logic                peak_current_threshold_i,
   input  wire logic                decay_switch_threshold_i,
   input  wire logic                overcurrent_fault_i,
   input  wire logic                standby_i,
   // Bridge gate drives and status
   output var  ccc_pkg::ccc_gate_t  gate_o,
   output var  ccc_pkg::ccc_phase_t phase_o,
   output var  logic                fault_o,
   output var  logic                period_start_o
);
   import ccc_pkg::*;

   localparam logic [`CCC_DIV_W-1:0]   DIV_LAST    = `CCC_DIV_W'(`CCC_OSC_DIV_CYC - 1);
   localparam logic [`CCC_TICK_W-1:0]  TICK_LAST   = `CCC_TICK_W'(`CCC_TICKS_PER_CHOP - 1);
   localparam logic [`CCC_DEAD_W-1:0]  DEAD_LOAD   = `CCC_DEAD_W'(`CCC_DEAD_CYC);
   localparam logic [`CCC_BLANK_W-1:0] PEAK_BLANK  = `CCC_BLANK_W'(`CCC_PEAK_BLANK_CYC);
   localparam logic [`CCC_BLANK_W-1:0] DECAY_BLANK = `CCC_BLANK_W'(`CCC_DECAY_BLANK_CYC);
   localparam ccc_gate_t               GATE_OFF    = `CCC_GATE_RST;
   localparam ccc_gate_t               GATE_CHARGE = 4'h9;
   localparam ccc_gate_t               GATE_FAST   = 4'h6;
   localparam ccc_gate_t               GATE_SLOW   = 4'h5;

   logic                    peak_hit;
   logic                    decay_hit;
   logic                    fault_in;
   logic                    standby_in;
   logic [`CCC_DIV_W-1:0]   div_cnt;
   logic [`CCC_TICK_W-1:0]  tick_cnt;
   logic [`CCC_DEAD_W-1:0]  dead_cnt;
   logic [`CCC_BLANK_W-1:0] blank_cnt;
   ccc_phase_t              state;
   ccc_phase_t              next_state;
   ccc_gate_t               target;
   logic                    fault;

   // Comparator and pin synchronisers
   ccc_sync u_sync_peak (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i (peak_current_threshold_i),
      .level_o (peak_hit)
   );
   ccc_sync u_sync_decay (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i (decay_switch_threshold_i),
      .level_o (decay_hit)
   );
   ccc_sync u_sync_fault (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i (overcurrent_fault_i),
      .level_o (fault_in)
   );
   ccc_sync u_sync_stby (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i (standby_i),
      .level_o (standby_in)
   );

   // Oscillator tick and chopping period
   wire osc_tick     = (div_cnt == DIV_LAST);
   wire period_start = osc_tick && (tick_cnt == TICK_LAST);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= osc_tick ? '0 : div_cnt + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt <= '0;
      end else if (osc_tick) begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_start_o <= 1'b0;
      end else begin
         period_start_o <= period_start;
      end
   end

   // Fault latch; new faults win over a standby clear
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault <= `CCC_FAULT_RST;
      end else if (fault_in) begin
         fault <= 1'b1;
      end else if (standby_in) begin
         fault <= 1'b0;
      end
   end

   assign fault_o = fault;

   // Blanking windows measured from phase entry
   wire entering    = (next_state != state);
   wire peak_armed  = (blank_cnt >= PEAK_BLANK);
   wire decay_armed = (blank_cnt >= DECAY_BLANK);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blank_cnt <= '0;
      end else if (entering) begin
         blank_cnt <= '0;
      end else if (!decay_armed) begin
         blank_cnt <= blank_cnt + 1'b1;
      end
   end

   // Phase sequencer
   always_comb begin
      next_state = state;
      case (state)
         CCC_CHARGE: begin
            if (peak_hit && peak_armed) begin
               next_state = CCC_FAST;
            end
         end
         CCC_FAST: begin
            if (decay_hit && decay_armed) begin
               next_state = CCC_SLOW;
            end
         end
         CCC_SLOW: begin
            if (period_start) begin
               next_state = CCC_CHARGE;
            end
         end
         CCC_IDLE: begin
            if (period_start) begin
               next_state = CCC_CHARGE;
            end
         end
         default: begin
            next_state = CCC_IDLE;
         end
      endcase
      // Charge and Fast Decay simply carry over a period boundary
      if (fault || fault_in || standby_in) begin
         next_state = CCC_IDLE;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= CCC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign phase_o = state;

   // Gate pattern of each phase
   always_comb begin
      case (state)
         CCC_CHARGE: target = GATE_CHARGE;
         CCC_FAST:   target = GATE_FAST;
         CCC_SLOW:   target = GATE_SLOW;
         default:    target = GATE_OFF;
      endcase
   end

   // All off first, then wait out the dead interval before the new pattern
   wire gate_off    = (gate_o == GATE_OFF);
   wire need_change = (target != gate_o);
   wire dead_done   = (dead_cnt == '0);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dead_cnt <= '0;
      end else if (need_change && !gate_off) begin
         dead_cnt <= DEAD_LOAD;
      end else if (!dead_done) begin
         dead_cnt <= dead_cnt - 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_o <= GATE_OFF;
      end else if (fault || fault_in) begin
         gate_o <= GATE_OFF;
      end else if (need_change && !gate_off) begin
         gate_o <= GATE_OFF;
      end else if (need_change && dead_done) begin
         gate_o <= target;
      end
   end

endmodule : ccc_chopper
`default_nettype wire

// >>> ccc_chopper_props.sv
// Port checker of the chopping sequencer
`default_nettype none
module ccc_chk (
   // Clock and reset
   input wire logic                clock_i,
   input wire logic                rst_n_i,
   // Comparator and protection inputs
   input wire logic                peak_current_threshold_i,
   input wire logic                decay_switch_threshold_i,
   input wire logic                overcurrent_fault_i,
   input wire logic                standby_i,
   // Gate drives and status
   input wire ccc_pkg::ccc_gate_t  gate_o,
   input wire ccc_pkg::ccc_phase_t phase_o,
   input wire logic                fault_o,
   input wire logic                period_start_o
);
   import ccc_pkg::*;
   logic [11:0] dw;
   logic [11:0] gp;
   ccc_phase_t  last;
   logic        seen;
   // Cycles since last phase change and since last period start
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last <= CCC_IDLE;
         dw   <= 12'h000;
         gp   <= 12'h000;
         seen <= 1'b0;
      end else begin
         last <= phase_o;
         dw   <= (phase_o != last) ? 12'h000 : dw + 12'h001;
         gp   <= period_start_o ? 12'h000 : gp + 12'h001;
         seen <= seen | period_start_o;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   property p_ord;
      phase_o != last && phase_o != CCC_IDLE && last != CCC_IDLE |->
         (last == CCC_CHARGE && phase_o == CCC_FAST) || (last == CCC_FAST && phase_o == CCC_SLOW) ||
         (last == CCC_SLOW && phase_o == CCC_CHARGE);
   endproperty
   property p_dead; $changed(gate_o) && gate_o != 4'h0 |-> $past(gate_o) == 4'h0 && $past(gate_o, 41) == 4'h0; endproperty
   property p_pblk; phase_o == CCC_FAST && last == CCC_CHARGE |-> dw >= 12'h07D; endproperty
   property p_dblk; phase_o == CCC_SLOW && last == CCC_FAST |-> dw >= 12'h0DC; endproperty
   property p_per; period_start_o && seen |-> gp == 12'h6BF; endproperty
   property p_flt; overcurrent_fault_i [*5] |-> ##[0:2] (fault_o && gate_o == 4'h0 && phase_o == CCC_IDLE); endproperty
   property p_chg; period_start_o && last == CCC_SLOW && !fault_o |-> phase_o == CCC_CHARGE; endproperty
   property p_carry; period_start_o && last inside {CCC_CHARGE, CCC_FAST} && !fault_o |-> phase_o == last; endproperty
   a_ord: assert property (p_ord) else $error("phase order");
   a_dead: assert property (p_dead) else $error("dead interval");
   a_pblk: assert property (p_pblk) else $error("peak blank");
   a_dblk: assert property (p_dblk) else $error("decay blank");
   a_per: assert property (p_per) else $error("period length");
   a_flt: assert property (p_flt) else $error("fault response");
   a_chg: assert property (p_chg) else $error("charge start");
   a_carry: assert property (p_carry) else $error("carry over");
   c_fast: cover property (last == CCC_CHARGE && phase_o == CCC_FAST);
   c_carry: cover property (period_start_o && last == CCC_FAST);
   c_flt: cover property ($rose(fault_o));
endmodule : ccc_chk
bind ccc_chopper ccc_chk chk (.clock_i, .rst_n_i, .peak_current_threshold_i, .decay_switch_threshold_i,
   .overcurrent_fault_i, .standby_i, .gate_o, .phase_o, .fault_o, .period_start_o);
`default_nettype wire

// >>> ccc_bridge.sv
// Bridge winding and comparator model
`default_nettype none
module ccc_bridge (
   // Clock and gate drives from the sequencer
   input  wire logic               clock_i,
   input  wire ccc_pkg::ccc_gate_t gate_i,
   // Cycles until each comparator trips
   input  wire logic [11:0]        chg_i,
   input  wire logic [11:0]        dec_i,
   // Comparator outputs
   output var  logic               peak_o,
   output var  logic               dec_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] on = 12'h000;
   logic [3:0]  prev = 4'h0;
   always @(posedge clock_i) begin
      prev <= gate_i;
      on   <= (gate_i !== prev) ? 12'h000 : on + 12'h001;
   end
   // Current climbs while charging, sinks in fast decay
   assign peak_o = gate_i === 4'h9 && on >= chg_i;
   assign dec_o  = gate_i === 4'h6 && on >= dec_i;
endmodule : ccc_bridge
`default_nettype wire

// >>> ccc_chopper_bench.sv
// Self-checking bench of the chopping sequencer
`default_nettype none
module ccc_chopper_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ccc_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        overcurrent_fault_i = 1'b0;
   logic        standby_i = 1'b0;
   logic        peak_current_threshold_i;
   logic        decay_switch_threshold_i;
   logic        fault_o;
   logic        period_start_o;
   ccc_gate_t   gate_o;
   ccc_phase_t  phase_o;
   logic [11:0] chg = 12'h005;
   logic [11:0] dec = 12'h005;
   int          fail_count = 0;
   int          checks_done = 0;
   int          n;
   always #5 clock_i = ~clock_i;
   ccc_chopper uut (.clock_i, .rst_n_i, .peak_current_threshold_i, .decay_switch_threshold_i,
      .overcurrent_fault_i, .standby_i, .gate_o, .phase_o, .fault_o, .period_start_o);
   ccc_bridge far (.clock_i, .gate_i(gate_o), .chg_i(chg), .dec_i(dec),
      .peak_o(peak_current_threshold_i), .dec_o(decay_switch_threshold_i));
   task automatic chk(input logic [11:0] s, input logic [11:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // Wait for a period start, or else for a phase change
   task automatic wt(input logic ps);
      ccc_phase_t p;
      p = phase_o;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while ((ps ? period_start_o !== 1'b1 : phase_o === p) && n < 4000);
      if (n >= 4000) fail_count++;
   endtask : wt
   task automatic t_cycle;
      wt(1'b1);
      chk({10'h000, phase_o}, 12'h000);
      wt(1'b0);
      chk({10'h000, phase_o}, 12'h001);
      chk({11'h000, n > 124}, 12'h001);
      // Gates drop to all off one edge after the phase change
      @(negedge clock_i);
      chk({8'h00, gate_o}, 12'h000);
      wt(1'b0);
      chk({10'h000, phase_o}, 12'h002);
      chk({11'h000, n > 219}, 12'h001);
      wt(1'b0);
      chk({10'h000, phase_o}, 12'h000);
      chk({11'h000, period_start_o}, 12'h001);
   endtask : t_cycle
   task automatic t_carry;
      chg = 12'hBB8;
      wt(1'b1);
      chk(n[11:0], 12'h6C0);
      chk({10'h000, phase_o}, 12'h000);
      wt(1'b0);
      dec = 12'hBB8;
      wt(1'b1);
      chk({10'h000, phase_o}, 12'h001);
      chg = 12'h005;
      dec = 12'h005;
      wt(1'b0);
      chk({10'h000, phase_o}, 12'h002);
   endtask : t_carry
   task automatic t_fault;
      overcurrent_fault_i = 1'b1;
      @(negedge clock_i);
      chk({11'h000, fault_o}, 12'h000);
      repeat (8) @(negedge clock_i);
      chk({5'h00, fault_o, gate_o, phase_o}, 12'h043);
      overcurrent_fault_i = 1'b0;
      wt(1'b1);
      chk({5'h00, fault_o, gate_o, phase_o}, 12'h043);
      standby_i = 1'b1;
      repeat (8) @(negedge clock_i);
      standby_i = 1'b0;
      chk({11'h000, fault_o}, 12'h000);
      wt(1'b1);
      chk({10'h000, phase_o}, 12'h000);
   endtask : t_fault
   task automatic stop_test;
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (6) @(negedge clock_i);
      rst_n_i = 1'b1;
      t_cycle();
      t_carry();
      t_fault();
      stop_test();
   end
   initial begin
      #400000;
      fail_count++;
      stop_test();
   end
endmodule : ccc_chopper_bench
`default_nettype wire
